/* File: hdl/lmx_pkg.sv */
// package for the logic/move instruction executor: opcodes, fields, resets.
// assumes a 12-bit instruction word and an 8-bit datapath.
package lmx_pkg;
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  // opcode patterns and masks
  localparam logic [11:0] OP_MASK_LIT = 12'hf00;
  localparam logic [11:0] OP_OR_LIT = 12'hd00;
  localparam logic [11:0] OP_LOAD_LIT = 12'hc00;
  localparam logic [11:0] OP_MASK_FD = 12'hfc0;
  localparam logic [11:0] OP_OR_FILE = 12'h100;
  localparam logic [11:0] OP_MOVE_FILE = 12'h200;
  localparam logic [11:0] OP_MASK_F = 12'hfe0;
  localparam logic [11:0] OP_STORE_ACC = 12'h020;
  localparam logic [11:0] OP_LOAD_OPTION = 12'h002;
  localparam logic [11:0] OP_NOP = 12'h000;
  // field positions
  localparam int DEST_BIT = 5;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hff;
  localparam logic ZERO_RST = 1'b0;
  // one instruction cycle = this many core clocks
  localparam int INSTR_CYCLES = 1;

  typedef enum {
    LMX_OP_NOP,
    LMX_OP_OR_LIT,
    LMX_OP_LOAD_LIT,
    LMX_OP_OR_FILE,
    LMX_OP_MOVE_FILE,
    LMX_OP_STORE_ACC,
    LMX_OP_OPTION,
    LMX_OP_OTHER
  } lmx_op_t;

  // decoded instruction carrier
  typedef struct packed {
    logic [7:0] literal;
    logic [4:0] faddr;
    logic to_file;
  } lmx_fields_t;

  // file register write request
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } lmx_fwrite_t;
endpackage : lmx_pkg

/* File: hdl/lmx_decode.sv */
// pure decoder: classifies one instruction word and splits its fields.
// assumes the word is stable in the cycle it is flagged valid.
module lmx_decode (
  // instruction
  input wire logic [11:0] instr_in,
  // decoded
  output lmx_pkg::lmx_op_t op_out,
  output lmx_pkg::lmx_fields_t fields_out
);
  always_comb begin
    fields_out.literal = instr_in[7:0];
    fields_out.faddr = instr_in[4:0];
    fields_out.to_file = instr_in[lmx_pkg::DEST_BIT];
    if ((instr_in & lmx_pkg::OP_MASK_LIT) == lmx_pkg::OP_OR_LIT) begin
      op_out = lmx_pkg::LMX_OP_OR_LIT;
    end else if ((instr_in & lmx_pkg::OP_MASK_LIT) ==
                 lmx_pkg::OP_LOAD_LIT) begin
      op_out = lmx_pkg::LMX_OP_LOAD_LIT;
    end else if ((instr_in & lmx_pkg::OP_MASK_FD) ==
                 lmx_pkg::OP_OR_FILE) begin
      op_out = lmx_pkg::LMX_OP_OR_FILE;
    end else if ((instr_in & lmx_pkg::OP_MASK_FD) ==
                 lmx_pkg::OP_MOVE_FILE) begin
      op_out = lmx_pkg::LMX_OP_MOVE_FILE;
    end else if ((instr_in & lmx_pkg::OP_MASK_F) ==
                 lmx_pkg::OP_STORE_ACC) begin
      op_out = lmx_pkg::LMX_OP_STORE_ACC;
    end else if (instr_in == lmx_pkg::OP_LOAD_OPTION) begin
      op_out = lmx_pkg::LMX_OP_OPTION;
    end else if (instr_in == lmx_pkg::OP_NOP) begin
      op_out = lmx_pkg::LMX_OP_NOP;
    end else begin
      op_out = lmx_pkg::LMX_OP_OTHER;
    end
  end
endmodule : lmx_decode

/* File: hdl/lmx_exec.sv */
// executor for the OR, move, nop and option-load instructions.
// assumes fetch hands one word per valid pulse and the file register
// array answers file_rdata_in combinationally for file_raddr_out.
//
// How it works
// RULE_01: OR-literal (1101 kkkk kkkk) ORs k into acc, sets zero, one cycle.
// RULE_02: OR-file (0001 00df ffff) ORs acc with file, sets zero, one cycle.
// RULE_03: register logic ops send result to acc when d=0, to file when d=1.
// RULE_04: move-file (0010 00df ffff) copies file to chosen dest, one cycle.
// RULE_05: move-file always updates zero, even writing back to the same file.
// RULE_06: move-file with d=1 writes back the addressed file, not the acc.
// RULE_07: store-acc (0000 001f ffff) writes acc to file, flags untouched.
// RULE_08: 0000 0000 0010 loads acc into option register, flags untouched.
// RULE_09: load-literal (1100 kkkk kkkk) puts k in acc, flags untouched.
// RULE_10: all-zero word changes nothing for one cycle.
module lmx_exec (
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // instruction from fetch
  input wire logic instr_valid_in,
  input wire logic [11:0] instr_in,
  // file register array
  output logic [4:0] file_raddr_out,
  input wire logic [7:0] file_rdata_in,
  output lmx_pkg::lmx_fwrite_t file_wr_out,
  // architectural state
  output logic [7:0] acc_out,
  output logic zero_flag_out,
  output logic [7:0] option_out,
  output logic done_out,
  output logic unsupported_out
);
  lmx_pkg::lmx_op_t op;
  lmx_pkg::lmx_fields_t fld;
  logic [7:0] result;
  logic [7:0] acc_q;
  logic zero_q;
  logic [7:0] option_q;
  lmx_pkg::lmx_fwrite_t fwr_q;
  logic done_q;
  logic unsup_q;

  lmx_decode u_dec (
    .instr_in(instr_in),
    .op_out(op),
    .fields_out(fld)
  );

  // file read is combinational so the whole op fits one clock
  assign file_raddr_out = fld.faddr;

  always_comb begin
    unique case (op)
      lmx_pkg::LMX_OP_OR_LIT: result = acc_q | fld.literal; // [RULE_01]
      lmx_pkg::LMX_OP_OR_FILE: result = acc_q | file_rdata_in; // [RULE_02]
      lmx_pkg::LMX_OP_MOVE_FILE: result = file_rdata_in; // [RULE_04]
      lmx_pkg::LMX_OP_LOAD_LIT: result = fld.literal; // [RULE_09]
      default: result = acc_q;
    endcase
  end

  function automatic logic writes_acc(lmx_pkg::lmx_op_t o, logic to_file);
    writes_acc = (o == lmx_pkg::LMX_OP_OR_LIT) ||
                 (o == lmx_pkg::LMX_OP_LOAD_LIT) ||
                 (((o == lmx_pkg::LMX_OP_OR_FILE) ||
                   (o == lmx_pkg::LMX_OP_MOVE_FILE)) && !to_file);
  endfunction : writes_acc

  // accumulator
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acc_q <= lmx_pkg::ACC_RST;
    end else if (instr_valid_in && writes_acc(op, fld.to_file)) begin
      acc_q <= result; // [RULE_03] [RULE_09]
    end
  end

  // zero flag: only OR and move touch it
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      zero_q <= lmx_pkg::ZERO_RST;
    end else if (instr_valid_in && (op == lmx_pkg::LMX_OP_OR_LIT ||
                 op == lmx_pkg::LMX_OP_OR_FILE ||
                 op == lmx_pkg::LMX_OP_MOVE_FILE)) begin
      zero_q <= (result == 8'h00); // [RULE_01] [RULE_02] [RULE_05]
    end
  end

  // option register
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      option_q <= lmx_pkg::OPTION_RST;
    end else if (instr_valid_in && op == lmx_pkg::LMX_OP_OPTION) begin
      option_q <= acc_q; // [RULE_08]
    end
  end

  // file write port, registered: one-cycle strobe after the op
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fwr_q <= '0;
    end else begin
      fwr_q.en <= 1'b0;
      fwr_q.addr <= fld.faddr;
      fwr_q.data <= result;
      if (instr_valid_in) begin
        if (op == lmx_pkg::LMX_OP_STORE_ACC) begin
          fwr_q.en <= 1'b1; // [RULE_07]
          fwr_q.data <= acc_q;
        end else if ((op == lmx_pkg::LMX_OP_OR_FILE ||
                      op == lmx_pkg::LMX_OP_MOVE_FILE) && fld.to_file) begin
          fwr_q.en <= 1'b1; // [RULE_03] [RULE_06]
        end
      end
    end
  end

  // completion and unsupported-word pulses
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_q <= 1'b0;
      unsup_q <= 1'b0;
    end else begin
      done_q <= instr_valid_in && op != lmx_pkg::LMX_OP_OTHER; // [RULE_10]
      unsup_q <= instr_valid_in && op == lmx_pkg::LMX_OP_OTHER;
    end
  end

  assign acc_out = acc_q;
  assign zero_flag_out = zero_q;
  assign option_out = option_q;
  assign file_wr_out = fwr_q;
  assign done_out = done_q;
  assign unsupported_out = unsup_q;

  a_or_lit_zero: assert property ( // [RULE_01]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_OR_LIT |=>
    acc_q == ($past(acc_q) | $past(fld.literal)) &&
    zero_q == (acc_q == 8'h00))
    else $error("or literal result wrong");

  a_or_file_zero: assert property ( // [RULE_02]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_OR_FILE |=>
    zero_q == (($past(acc_q) | $past(file_rdata_in)) == 8'h00))
    else $error("or file zero flag wrong");

  a_dest_acc: assert property ( // [RULE_03]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_OR_FILE && !fld.to_file |=>
    !fwr_q.en && acc_q == ($past(acc_q) | $past(file_rdata_in)))
    else $error("or file d=0 misrouted");

  a_dest_file: assert property ( // [RULE_03]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_OR_FILE && fld.to_file |=>
    fwr_q.en && fwr_q.data == ($past(acc_q) | $past(file_rdata_in)) &&
    $stable(acc_q))
    else $error("or file d=1 misrouted");

  a_move_acc: assert property ( // [RULE_04]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_MOVE_FILE && !fld.to_file |=>
    acc_q == $past(file_rdata_in))
    else $error("move to acc wrong");

  a_move_test: assert property ( // [RULE_05]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_MOVE_FILE |=>
    zero_q == ($past(file_rdata_in) == 8'h00))
    else $error("move zero flag wrong");

  a_move_file: assert property ( // [RULE_06]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_MOVE_FILE && fld.to_file |=>
    fwr_q.en && fwr_q.addr == $past(instr_in[4:0]) &&
    fwr_q.data == $past(file_rdata_in) && $stable(acc_q))
    else $error("move d=1 misrouted");

  a_store_acc: assert property ( // [RULE_07]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_STORE_ACC |=>
    fwr_q.en && fwr_q.addr == $past(instr_in[4:0]) &&
    fwr_q.data == $past(acc_q) && $stable(zero_q))
    else $error("store acc wrong");

  a_option_load: assert property ( // [RULE_08]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_OPTION |=>
    option_q == $past(acc_q) && $stable(zero_q) && $stable(acc_q))
    else $error("option load wrong");

  a_load_lit: assert property ( // [RULE_09]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_LOAD_LIT |=>
    acc_q == $past(fld.literal) && $stable(zero_q))
    else $error("load literal wrong");

  a_nop_idle: assert property ( // [RULE_10]
    @(posedge mclk_in) disable iff (!resetn_in)
    instr_valid_in && op == lmx_pkg::LMX_OP_NOP |=>
    $stable(acc_q) && $stable(zero_q) && $stable(option_q) && !fwr_q.en
    && done_q)
    else $error("nop changed state");
endmodule : lmx_exec

/* File: verif/lmx_file_model.sv */
// file register array standing at the executor's far side.
// assumes writes come as a registered one-cycle pulse on the core clock.
module lmx_file_model (
  // clock
  input wire logic mclk_in,
  // read port, answered combinationally
  input wire logic [4:0] raddr_in,
  output logic [7:0] rdata_out,
  // write port
  input wire lmx_pkg::lmx_fwrite_t wr_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [32];
  // same start pattern as the bench shadow, so both begin equal
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem_q[i] = 8'(i * 37);
    end
  end
  assign rdata_out = mem_q[raddr_in];
  always @(posedge mclk_in) begin
    if (wr_in.en) begin
      mem_q[wr_in.addr] <= wr_in.data;
    end
  end
endmodule : lmx_file_model

/* File: verif/test_logic_and_move_instr_exec.sv */
// self-checking bench for the logic/move executor and its file array.
// assumes outputs settle within half a core clock (one negedge) after the taking edge.
module test_logic_and_move_instr_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic [11:0] instr_in = 12'h000;
  logic [4:0] file_raddr_out;
  logic [7:0] file_rdata_in, acc_out, option_out;
  logic zero_flag_out, done_out, unsupported_out;
  lmx_pkg::lmx_fwrite_t file_wr_out;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] acc_e = 8'h00;
  logic [7:0] opt_e = 8'hff;
  logic z_e = 1'b0;
  logic [7:0] mem_e [32];
  always #4 mclk_in = ~mclk_in;
  lmx_exec uut (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .file_raddr_out(file_raddr_out), .file_rdata_in(file_rdata_in),
    .file_wr_out(file_wr_out), .acc_out(acc_out),
    .zero_flag_out(zero_flag_out), .option_out(option_out),
    .done_out(done_out), .unsupported_out(unsupported_out));
  lmx_file_model far (.mclk_in(mclk_in), .raddr_in(file_raddr_out),
    .rdata_out(file_rdata_in), .wr_in(file_wr_out));
  task automatic chk(input string what, input logic [15:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  // one word, then an idle cycle so the file write lands before the next
  task automatic run(input logic [11:0] w);
    logic [7:0] f;
    logic [7:0] r;
    logic [13:0] wr;
    logic ok;
    f = mem_e[w[4:0]];
    wr = 14'h0000;
    ok = 1'b1;
    instr_in = w;
    instr_valid_in = 1'b1;
    casez (w)
      12'hd??: begin
        acc_e = acc_e | w[7:0];
        z_e = (acc_e == 8'h00);
      end
      12'hc??: acc_e = w[7:0];
      12'b0001_00??_????, 12'b0010_00??_????: begin
        r = w[9] ? f : (acc_e | f);
        z_e = (r == 8'h00);
        if (w[5]) wr = {1'b1, w[4:0], r};
        else acc_e = r;
      end
      12'b0000_001?_????: wr = {1'b1, w[4:0], acc_e};
      12'h002: opt_e = acc_e;
      12'h000: ;
      default: ok = 1'b0;
    endcase
    if (wr[13]) mem_e[w[4:0]] = wr[7:0];
    @(negedge mclk_in);
    instr_valid_in = 1'b0;
    chk("acc", 16'(acc_e), 16'(acc_out));
    chk("option", 16'(opt_e), 16'(option_out));
    chk("zero", 16'(z_e), 16'(zero_flag_out));
    chk("write en", 16'(wr[13]), 16'(file_wr_out.en));
    // addr and data only mean something while the strobe is up
    if (wr[13]) chk("file write", 16'(wr), 16'(file_wr_out));
    chk("done", 16'(ok), 16'(done_out));
    chk("unsupported", 16'(!ok), 16'(unsupported_out));
    @(negedge mclk_in);
    chk("pulse end", 16'h0000,
      16'({done_out, file_wr_out.en, unsupported_out}));
  endtask : run
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    logic [11:0] w;
    for (int i = 0; i < 32; i++) begin
      mem_e[i] = 8'(i * 37);
    end
    void'($urandom(80334));
    repeat (10) @(negedge mclk_in);
    resetn_in = 1'b1;
    chk("reset regs", 16'h00ff, {acc_out, option_out});
    chk("reset flags", 16'h0000,
      16'({zero_flag_out, done_out, file_wr_out.en, unsupported_out}));
    run(12'hc9a);
    run(12'hd35);
    run(12'hc00);
    run(12'hd00);
    run(12'h020);
    run(12'h000);
    run(12'hc07);
    run(12'h002);
    run(12'h12a);
    run(12'h10b);
    run(12'h260);
    run(12'h201);
    run(12'h280);
    $display("test corner cases done");
    for (int n = 0; n < 300; n++) begin
      w = 12'($urandom);
      case ($urandom % 8)
        0: w = {4'hd, w[7:0]};
        1: w = {4'hc, w[7:0]};
        2: w = {6'h04, w[5:0]};
        3: w = {6'h08, w[5:0]};
        4: w = {7'h01, w[4:0]};
        5: w = 12'h002;
        6: w = 12'h000;
        default: ;
      endcase
      run(w);
    end
    $display("test random words done");
    tally_and_finish();
  end
endmodule : test_logic_and_move_instr_exec
